// File: src/accr_channel_regs.sv
// Summary of operation
// - Gain code in bits 7:2 selects 0 to 42 dB; 43-63 reserved.
// - Volume code zero mutes channel output samples completely.
// - Nonzero volume in 0.5 dB steps: 1 is -100, 201 is 0, 255 is +27.
// - Volume register at 0x43 resets to unity code 0xc9.
// - Trim nibble bits 7:4 in 0.1 dB steps, 8 is no trim.
// - Trim register at 0x44 resets to 0x80, low nibble zero.
// - Phase code delays sampling by that many modulator cycles, 0 to 255.
// - Phase code zero, the reset value, adds no sampling delay.
// - Gain register at 0x42 resets to zero, 0 dB gain.
// - Third channel input setup at 0x46, reset zero, five fields.
// - Source: 0 differential, 1 single-ended, 2 pulse density mic, 3 reserved.
// - Enable bit clear disables both; set picks enhancer or level control.
`default_nettype none
module accr_channel_regs #(
  parameter int SAMPLE_W = 32
) (
  input  wire logic                REF_CLK,
  input  wire logic                RST_N,
  input  wire logic [7:0]          CTRL_PAGE,
  input  wire logic [6:0]          CTRL_ADDR,
  input  wire logic                CTRL_WR_EN,
  input  wire logic [7:0]          CTRL_WDATA,
  input  wire logic                CTRL_RD_EN,
  output logic      [7:0]          CTRL_RDATA,
  output logic                     CTRL_HIT,
  input  wire logic                ENHANCER_SELECT,
  input  wire logic                MOD_TICK,
  input  wire logic                SAMPLE_REQ,
  output logic                     SAMPLE_GO,
  input  wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  input  wire logic                SAMPLE_IN_VALID,
  output logic      [SAMPLE_W-1:0] SAMPLE_OUT,
  output logic                     SAMPLE_OUT_VALID,
  output logic      [5:0]          GAIN_DB,
  output logic                     GAIN_CODE_RESERVED,
  output logic                     VOLUME_MUTE,
  output logic signed [8:0]        VOLUME_HALF_DB,
  output logic signed [4:0]        TRIM_TENTH_DB,
  output logic      [7:0]          PHASE_DELAY_CYCLES,
  output logic                     IN3_LINE_INPUT,
  output logic                     IN3_SRC_ANALOG_DIFF,
  output logic                     IN3_SRC_ANALOG_SE,
  output logic                     IN3_SRC_PULSE_DENSITY_MIC,
  output logic                     IN3_SRC_RESERVED,
  output logic                     IN3_DC_COUPLED,
  output logic      [1:0]          IN3_IMPEDANCE,
  output logic                     IN3_RANGE_ENHANCER_EN,
  output logic                     IN3_LEVEL_CONTROL_EN
);

  // ==========================================================================
  // Masked write: only writable bits take new data
  function automatic logic [7:0] masked_write(
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    masked_write = wdata & mask;
  endfunction

  // ==========================================================================
  // Register storage
  logic [7:0] gain_r;
  logic [7:0] volume_r;
  logic [7:0] trim_r;
  logic [7:0] phase_r;
  logic [7:0] in3_setup_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [SAMPLE_W-1:0] sample_r;
  logic                sample_valid_r;

  // ==========================================================================
  // Address decode, page 0 only
  wire page_ok;
  wire sel_gain;
  wire sel_volume;
  wire sel_trim;
  wire sel_phase;
  wire sel_in3;

  assign page_ok    = (CTRL_PAGE == accr_pkg::PAGE_CFG);
  assign sel_gain   = page_ok && (CTRL_ADDR == accr_pkg::OFS_GAIN);
  assign sel_volume = page_ok && (CTRL_ADDR == accr_pkg::OFS_VOLUME);
  assign sel_trim   = page_ok && (CTRL_ADDR == accr_pkg::OFS_TRIM);
  assign sel_phase  = page_ok && (CTRL_ADDR == accr_pkg::OFS_PHASE);
  assign sel_in3    = page_ok && (CTRL_ADDR == accr_pkg::OFS_IN3_SETUP);
  assign CTRL_HIT   = sel_gain || sel_volume || sel_trim ||
                      sel_phase || sel_in3;

  // ==========================================================================
  // Register writes with reset values
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      gain_r      <= accr_pkg::RST_GAIN;
      volume_r    <= accr_pkg::RST_VOLUME;
      trim_r      <= accr_pkg::RST_TRIM;
      phase_r     <= accr_pkg::RST_PHASE;
      in3_setup_r <= accr_pkg::RST_IN3_SETUP;
    end else if (CTRL_WR_EN) begin
      if (sel_gain) begin
        gain_r <= masked_write(CTRL_WDATA, accr_pkg::MASK_GAIN);
      end
      if (sel_volume) begin
        volume_r <= masked_write(CTRL_WDATA, accr_pkg::MASK_VOLUME);
      end
      if (sel_trim) begin
        trim_r <= masked_write(CTRL_WDATA, accr_pkg::MASK_TRIM);
      end
      if (sel_phase) begin
        phase_r <= masked_write(CTRL_WDATA, accr_pkg::MASK_PHASE);
      end
      if (sel_in3) begin
        in3_setup_r <= masked_write(CTRL_WDATA,
                                    accr_pkg::MASK_IN3_SETUP);
      end
    end
  end

  // ==========================================================================
  // Read mux; unmapped addresses and other pages read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (sel_gain) begin
      rdata_nxt = gain_r;
    end else if (sel_volume) begin
      rdata_nxt = volume_r;
    end else if (sel_trim) begin
      rdata_nxt = trim_r;
    end else if (sel_phase) begin
      rdata_nxt = phase_r;
    end else if (sel_in3) begin
      rdata_nxt = in3_setup_r;
    end
  end

  // Read data register, held between reads
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else if (CTRL_RD_EN) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign CTRL_RDATA = rdata_r;

  // ==========================================================================
  // Second channel gain decode
  wire [5:0] gain_code;

  assign gain_code          = gain_r[accr_pkg::GAIN_LSB +: 6];
  assign GAIN_DB            = gain_code;
  assign GAIN_CODE_RESERVED = (gain_code >
                               accr_pkg::GAIN_MAX_CODE);

  // ==========================================================================
  // Digital volume: mute flag and signed half-dB setting
  wire [8:0] volume_ext;

  assign VOLUME_MUTE    = (volume_r == accr_pkg::VOL_MUTE_CODE);
  assign volume_ext     = {1'b0, volume_r};
  assign VOLUME_HALF_DB = signed'(volume_ext -
                                  accr_pkg::VOL_UNITY_CODE);

  // ==========================================================================
  // Gain trim in signed tenths of a dB
  wire [4:0] trim_ext;

  assign trim_ext      = {1'b0, trim_r[accr_pkg::TRIM_LSB +: 4]};
  assign TRIM_TENTH_DB = signed'(trim_ext -
                                 accr_pkg::TRIM_ZERO_CODE);

  // ==========================================================================
  // Sample output path; mute forces exact zero, not an attenuation
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sample_r       <= '0;
      sample_valid_r <= 1'b0;
    end else begin
      sample_valid_r <= SAMPLE_IN_VALID;
      if (SAMPLE_IN_VALID) begin
        sample_r <= VOLUME_MUTE ? '0 : SAMPLE_IN;
      end
    end
  end

  assign SAMPLE_OUT       = sample_r;
  assign SAMPLE_OUT_VALID = sample_valid_r;

  // ==========================================================================
  // Phase calibration: delay sampling by modulator cycles
  assign PHASE_DELAY_CYCLES = phase_r;

  accr_phase_delay u_phase_delay (
    .clk        (REF_CLK),
    .rst_n      (RST_N),
    .delay_code (phase_r),
    .mod_tick   (MOD_TICK),
    .sample_req (SAMPLE_REQ),
    .sample_go  (SAMPLE_GO)
  );

  // ==========================================================================
  // Third channel input setup decode
  wire [1:0] in3_src;
  wire       in3_enh;

  assign in3_src        = in3_setup_r[accr_pkg::IN3_SRC_LSB +: 2];
  assign IN3_LINE_INPUT = in3_setup_r[accr_pkg::IN3_KIND_BIT];
  assign IN3_DC_COUPLED = in3_setup_r[accr_pkg::IN3_COUPLE_BIT];
  assign IN3_IMPEDANCE  = in3_setup_r[accr_pkg::IN3_IMP_LSB +: 2];

  // One-hot source decode
  assign IN3_SRC_ANALOG_DIFF =
    (in3_src == accr_pkg::SRC_ANA_DIFF);
  assign IN3_SRC_ANALOG_SE =
    (in3_src == accr_pkg::SRC_ANA_SE);
  assign IN3_SRC_PULSE_DENSITY_MIC =
    (in3_src == accr_pkg::SRC_PULSE_DENSITY_MIC);
  assign IN3_SRC_RESERVED =
    (in3_src == accr_pkg::SRC_RESERVED);

  // Enhancer or level control, picked by the global select
  assign in3_enh               = in3_setup_r[accr_pkg::IN3_ENH_BIT];
  assign IN3_RANGE_ENHANCER_EN = in3_enh && ENHANCER_SELECT;
  assign IN3_LEVEL_CONTROL_EN  = in3_enh && !ENHANCER_SELECT;

endmodule
`default_nettype wire

// File: src/accr_pkg.sv
`default_nettype none
package accr_pkg;

  // ==========================================================================
  // Control port page and register offsets
  localparam logic [7:0] PAGE_CFG      = 8'h00;
  localparam logic [6:0] OFS_GAIN      = 7'h42;
  localparam logic [6:0] OFS_VOLUME    = 7'h43;
  localparam logic [6:0] OFS_TRIM      = 7'h44;
  localparam logic [6:0] OFS_PHASE     = 7'h45;
  localparam logic [6:0] OFS_IN3_SETUP = 7'h46;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_GAIN      = 8'h00;
  localparam logic [7:0] RST_VOLUME    = 8'hc9;
  localparam logic [7:0] RST_TRIM      = 8'h80;
  localparam logic [7:0] RST_PHASE     = 8'h00;
  localparam logic [7:0] RST_IN3_SETUP = 8'h00;

  // ==========================================================================
  // Writable bit masks; cleared bits are reserved and read zero
  localparam logic [7:0] MASK_GAIN      = 8'hfc;
  localparam logic [7:0] MASK_VOLUME    = 8'hff;
  localparam logic [7:0] MASK_TRIM      = 8'hf0;
  localparam logic [7:0] MASK_PHASE     = 8'hff;
  localparam logic [7:0] MASK_IN3_SETUP = 8'hfd;

  // ==========================================================================
  // Field positions
  localparam int GAIN_LSB       = 2;
  localparam int TRIM_LSB       = 4;
  localparam int IN3_KIND_BIT   = 7;
  localparam int IN3_SRC_LSB    = 5;
  localparam int IN3_COUPLE_BIT = 4;
  localparam int IN3_IMP_LSB    = 2;
  localparam int IN3_ENH_BIT    = 0;

  // ==========================================================================
  // Field codes
  localparam logic [5:0] GAIN_MAX_CODE  = 6'h2a;
  localparam logic [7:0] VOL_MUTE_CODE  = 8'h00;
  localparam logic [8:0] VOL_UNITY_CODE = 9'h0c9;
  localparam logic [4:0] TRIM_ZERO_CODE = 5'h08;
  localparam logic [1:0] SRC_ANA_DIFF   = 2'h0;
  localparam logic [1:0] SRC_ANA_SE     = 2'h1;
  localparam logic [1:0] SRC_PULSE_DENSITY_MIC = 2'h2;
  localparam logic [1:0] SRC_RESERVED   = 2'h3;
  localparam logic [1:0] IMP_RESERVED   = 2'h3;

  // ==========================================================================
  // Phase delay sequencer states
  typedef enum logic [1:0] {
    ACCR_DLY_IDLE = 2'b01,
    ACCR_DLY_WAIT = 2'b10
  } accr_dly_state_e;

endpackage
`default_nettype wire

// File: src/accr_phase_delay.sv
`default_nettype none
module accr_phase_delay (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] delay_code,
  input  wire logic       mod_tick,
  input  wire logic       sample_req,
  output logic            sample_go
);

  // ==========================================================================
  // State and remaining modulator cycles
  accr_pkg::accr_dly_state_e state_r;
  accr_pkg::accr_dly_state_e state_nxt;
  logic [7:0]                cnt_r;
  logic [7:0]                cnt_nxt;
  wire                       zero_delay;
  wire                       last_tick;
  wire                       idle_now;

  // Zero code passes the request through, no added delay
  assign idle_now   = (state_r == accr_pkg::ACCR_DLY_IDLE);
  assign zero_delay = (delay_code == 8'h00);
  assign last_tick  = (state_r == accr_pkg::ACCR_DLY_WAIT) &&
                      mod_tick && (cnt_r == 8'h01);
  // Requests during a wait are dropped, even at code zero
  assign sample_go  = (idle_now && sample_req && zero_delay) ||
                      last_tick;

  // Next state: count one modulator cycle per tick
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      accr_pkg::ACCR_DLY_IDLE: begin
        if (sample_req && !zero_delay) begin
          state_nxt = accr_pkg::ACCR_DLY_WAIT;
          cnt_nxt   = delay_code;
        end
      end
      accr_pkg::ACCR_DLY_WAIT: begin
        if (mod_tick) begin
          cnt_nxt = cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            state_nxt = accr_pkg::ACCR_DLY_IDLE;
          end
        end
      end
      default: begin
        state_nxt = accr_pkg::ACCR_DLY_IDLE;
        cnt_nxt   = 8'h00;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= accr_pkg::ACCR_DLY_IDLE;
      cnt_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// File: verification/accr_channel_regs_sva.sv
`default_nettype none
module accr_channel_regs_sva #(
  parameter int SAMPLE_W = 32
) (
  input wire logic                REF_CLK,
  input wire logic                RST_N,
  input wire logic [6:0]          CTRL_ADDR,
  input wire logic                CTRL_WR_EN,
  input wire logic [7:0]          CTRL_WDATA,
  input wire logic                CTRL_RD_EN,
  input wire logic [7:0]          CTRL_RDATA,
  input wire logic                CTRL_HIT,
  input wire logic                MOD_TICK,
  input wire logic                SAMPLE_REQ,
  input wire logic                SAMPLE_GO,
  input wire logic                SAMPLE_IN_VALID,
  input wire logic [SAMPLE_W-1:0] SAMPLE_OUT,
  input wire logic                SAMPLE_OUT_VALID,
  input wire logic [5:0]          GAIN_DB,
  input wire logic                GAIN_CODE_RESERVED,
  input wire logic                VOLUME_MUTE,
  input wire logic signed [8:0]   VOLUME_HALF_DB,
  input wire logic signed [4:0]   TRIM_TENTH_DB,
  input wire logic [7:0]          PHASE_DELAY_CYCLES
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Helper logic
  logic       wait_r;
  logic [7:0] ticks_r;
  wire        start  = SAMPLE_REQ && !wait_r;
  wire        wr_hit = CTRL_WR_EN && CTRL_HIT;

  // Open delay wait and ticks seen since the request
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wait_r  <= 1'b0;
      ticks_r <= 8'h00;
    end else if (start) begin
      wait_r  <= !SAMPLE_GO;
      ticks_r <= 8'h00;
    end else if (wait_r) begin
      wait_r  <= !SAMPLE_GO;
      ticks_r <= ticks_r + {7'h00, MOD_TICK};
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  AST_RESET_VALUES: assert property ($rose(RST_N)
    |-> GAIN_DB == 6'h00 && !VOLUME_MUTE && VOLUME_HALF_DB == 9'sh000)
    else $error("bad gain or volume after reset");
  AST_RESET_CAL: assert property ($rose(RST_N)
    |-> TRIM_TENTH_DB == 5'sh00 && PHASE_DELAY_CYCLES == 8'h00)
    else $error("bad trim or phase after reset");
  AST_OFFMAP_READ: assert property (CTRL_RD_EN && !CTRL_HIT
    |=> CTRL_RDATA == 8'h00) else $error("unmapped read not zero");
  AST_GAIN_WRITE: assert property (wr_hit && CTRL_ADDR == 7'h42
    |=> GAIN_DB == $past(CTRL_WDATA[7:2])
    && GAIN_CODE_RESERVED == ($past(CTRL_WDATA[7:2]) > 6'h2a))
    else $error("gain decode wrong");
  AST_VOL_WRITE: assert property (wr_hit && CTRL_ADDR == 7'h43
    |=> VOLUME_MUTE == ($past(CTRL_WDATA) == 8'h00) && VOLUME_HALF_DB
    == $signed({1'b0, $past(CTRL_WDATA)} - 9'h0c9))
    else $error("volume decode wrong");
  AST_MUTE_SAMPLE: assert property (SAMPLE_IN_VALID && VOLUME_MUTE
    |=> SAMPLE_OUT_VALID && SAMPLE_OUT == '0) else $error("mute leaked");
  AST_TRIM_WRITE: assert property (wr_hit && CTRL_ADDR == 7'h44
    |=> TRIM_TENTH_DB == $signed({1'b0, $past(CTRL_WDATA[7:4])} - 5'h08))
    else $error("trim decode wrong");
  AST_PHASE_ZERO: assert property (start
    && PHASE_DELAY_CYCLES == 8'h00 |-> SAMPLE_GO)
    else $error("zero delay not immediate");
  AST_PHASE_COUNT: assert property (wait_r && SAMPLE_GO
    |-> MOD_TICK && ticks_r == PHASE_DELAY_CYCLES - 8'h01)
    else $error("delay count off");

  // Main scenarios reached
  cover property (SAMPLE_IN_VALID && VOLUME_MUTE);
  cover property (wait_r && SAMPLE_GO);
  cover property (CTRL_RD_EN && !CTRL_HIT);
endmodule

bind accr_channel_regs accr_channel_regs_sva #(.SAMPLE_W(SAMPLE_W))
  u_sva (.*);
`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic        REF_CLK = 1'b0, RST_N = 1'b0, CTRL_WR_EN = 1'b0;
  logic        CTRL_RD_EN = 1'b0, ENHANCER_SELECT = 1'b0, MOD_TICK = 1'b0;
  logic        SAMPLE_REQ = 1'b0, SAMPLE_IN_VALID = 1'b0;
  logic [7:0]  CTRL_PAGE = 8'h00, CTRL_WDATA = 8'h00, CTRL_RDATA;
  logic [6:0]  CTRL_ADDR = 7'h00;
  logic [31:0] SAMPLE_IN = 32'h0, SAMPLE_OUT;
  logic        CTRL_HIT, SAMPLE_GO, SAMPLE_OUT_VALID, GAIN_CODE_RESERVED;
  logic        VOLUME_MUTE, IN3_LINE_INPUT, IN3_SRC_ANALOG_DIFF;
  logic        IN3_SRC_PULSE_DENSITY_MIC;
  logic        IN3_SRC_ANALOG_SE, IN3_SRC_RESERVED, IN3_DC_COUPLED;
  logic        IN3_RANGE_ENHANCER_EN, IN3_LEVEL_CONTROL_EN;
  logic [5:0]  GAIN_DB;
  logic [1:0]  IN3_IMPEDANCE;
  logic [7:0]  PHASE_DELAY_CYCLES;
  logic signed [8:0] VOLUME_HALF_DB;
  logic signed [4:0] TRIM_TENTH_DB;
  int          miscompares = 0, comparisons = 0, go_at = 0;
  logic [7:0]  rst_t [5] = '{8'h00, 8'hc9, 8'h80, 8'h00, 8'h00};
  logic [7:0]  msk_t [5] = '{8'hfc, 8'hff, 8'hf0, 8'hff, 8'hfd};
  logic [7:0]  vol_t [4] = '{8'h01, 8'hca, 8'hff, 8'hc9};
  logic [8:0]  hdb_t [4] = '{9'h138, 9'h001, 9'h036, 9'h000};

  accr_channel_regs #(.SAMPLE_W(32)) u_dut (.*);

  // 200 MHz clock
  always #2.5 REF_CLK = ~REF_CLK;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] pg, input logic [6:0] a,
                    input logic [7:0] d);
    @(posedge REF_CLK);
    CTRL_PAGE  <= pg;
    CTRL_ADDR  <= a;
    CTRL_WDATA <= d;
    CTRL_WR_EN <= 1'b1;
    @(posedge REF_CLK);
    CTRL_WR_EN <= 1'b0;
    @(negedge REF_CLK);
  endtask

  task automatic rd(input logic [7:0] pg, input logic [6:0] a,
                    input logic [7:0] exp);
    @(posedge REF_CLK);
    CTRL_PAGE  <= pg;
    CTRL_ADDR  <= a;
    CTRL_RD_EN <= 1'b1;
    @(posedge REF_CLK);
    CTRL_RD_EN <= 1'b0;
    @(negedge REF_CLK);
    chk({24'h0, CTRL_RDATA}, {24'h0, exp});
  endtask

  task automatic samp(input logic [31:0] exp);
    @(posedge REF_CLK);
    SAMPLE_IN       <= 32'h12345678;
    SAMPLE_IN_VALID <= 1'b1;
    @(posedge REF_CLK);
    SAMPLE_IN_VALID <= 1'b0;
    @(negedge REF_CLK);
    chk({31'h0, SAMPLE_OUT_VALID}, 32'h1);
    chk(SAMPLE_OUT, exp);
  endtask

  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'h00, 7'h42 + 7'(i), rst_t[i]);
      wr(8'h00, 7'h42 + 7'(i), 8'hff);
      rd(8'h00, 7'h42 + 7'(i), msk_t[i]);
      wr(8'h00, 7'h42 + 7'(i), 8'h00);
      rd(8'h00, 7'h42 + 7'(i), 8'h00);
    end
    wr(8'h00, 7'h42, 8'ha8);
    chk({25'h0, GAIN_CODE_RESERVED, GAIN_DB}, 32'h2a);
    wr(8'h00, 7'h42, 8'hac);
    chk({25'h0, GAIN_CODE_RESERVED, GAIN_DB}, 32'h6b);
    wr(8'h01, 7'h42, 8'h54);
    rd(8'h00, 7'h42, 8'hac);
    chk({31'h0, CTRL_HIT}, 32'h1);
    rd(8'h01, 7'h42, 8'h00);
    chk({31'h0, CTRL_HIT}, 32'h0);
    rd(8'h00, 7'h47, 8'h00);
    chk({31'h0, CTRL_HIT}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 7'h43, vol_t[i]);
      chk({22'h0, VOLUME_MUTE, VOLUME_HALF_DB}, {23'h0, hdb_t[i]});
    end
    samp(32'h12345678);
    wr(8'h00, 7'h43, 8'h00);
    chk({31'h0, VOLUME_MUTE}, 32'h1);
    samp(32'h0);
    wr(8'h00, 7'h44, 8'h0f);
    chk({27'h0, TRIM_TENTH_DB}, 32'h18);
    wr(8'h00, 7'h44, 8'hf0);
    chk({27'h0, TRIM_TENTH_DB}, 32'h07);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 7'h46, {1'b0, 2'(s), 5'h00});
      chk({IN3_SRC_RESERVED, IN3_SRC_PULSE_DENSITY_MIC,
           IN3_SRC_ANALOG_SE, IN3_SRC_ANALOG_DIFF}, 32'h1 << s);
    end
    wr(8'h00, 7'h46, 8'h95);
    chk({IN3_LINE_INPUT, IN3_DC_COUPLED, IN3_IMPEDANCE}, 32'hd);
    for (int e = 0; e < 2; e++) begin
      @(posedge REF_CLK);
      ENHANCER_SELECT <= 1'(e);
      @(negedge REF_CLK);
      chk({IN3_RANGE_ENHANCER_EN, IN3_LEVEL_CONTROL_EN},
          32'h1 << e);
    end
    wr(8'h00, 7'h46, 8'h94);
    chk({IN3_RANGE_ENHANCER_EN, IN3_LEVEL_CONTROL_EN}, 32'h0);
    @(posedge REF_CLK);
    SAMPLE_REQ <= 1'b1;
    @(negedge REF_CLK);
    chk({31'h0, SAMPLE_GO}, 32'h1);
    @(posedge REF_CLK);
    SAMPLE_REQ <= 1'b0;
    wr(8'h00, 7'h45, 8'h03);
    @(posedge REF_CLK);
    SAMPLE_REQ <= 1'b1;
    MOD_TICK   <= 1'b1;
    for (int i = 1; i < 11; i++) begin
      @(posedge REF_CLK);
      SAMPLE_REQ <= (i == 2);
      MOD_TICK   <= (i % 2 == 0);
      @(negedge REF_CLK);
      if (SAMPLE_GO === 1'b1) go_at = go_at * 16 + i;
    end
    chk(go_at, 32'h6);
    close_out();
  end

  // Hang guard
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
